/* pkg/ssa_consts.svh */
// Purpose: timing counts, widths and reset values of the serial sar sequencer
// Assumes: counts are in periods of the internal oscillator tick
// Notes:   included by the package, the sequencer and the property checks
`ifndef SSA_CONSTS_SVH
`define SSA_CONSTS_SVH

`define SSA_SHIFT_W      9
`define SSA_CODE_W       8
`define SSA_CHAN_W       2
`define SSA_TICK_W       6
`define SSA_READY_W      3

// one conversion, end to end
`define SSA_CONV_TICKS   6'h38
// oscillator ticks after select falls before serial data is valid
`define SSA_READY_TICKS  3'h5
// settle time before the first trial bit
`define SSA_SAMPLE_TICKS 6'h08
// ticks per trial bit; the compare is taken at the last tick of a step
`define SSA_STEP_TICKS   6'h06
`define SSA_DECIDE_OFS   6'h05

`define SSA_SHIFT_RST    9'h000
`define SSA_CODE_RST     8'h00
`define SSA_CHAN_RST     2'h0

`endif

/* pkg/ssa_pkg.sv */
// Purpose: types shared by the serial sar sequencer files
// Assumes: constants come from ssa_consts.svh
// Notes:   host pins travel together as one packed struct
`include "ssa_consts.svh"

package ssa_pkg;

  typedef enum logic [1:0] {
    SSA_ST_IFACE = 2'b01,
    SSA_ST_CONV  = 2'b10
  } ssa_state_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic addr_latch_strobe;
  } ssa_host_pins_t;

  typedef struct packed {
    logic so_oe;
    logic eoc_n_oe;
  } ssa_pin_oe_t;

endpackage : ssa_pkg

/* rtl/ssa_edge.sv */
// Purpose: rise and fall detect of one input level on core_clk
// Assumes: input is already synchronous to core_clk
// Notes:   reset value chosen per pin so no false edge after reset
`timescale 1ns/1ns

module ssa_edge #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // level in
  input  wire logic sig,
  // edges out
  output logic      rise,
  output logic      fall
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = sig;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_q <= RST_VAL;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;

endmodule : ssa_edge

/* rtl/ssa_sequencer.sv */
// Purpose: serial host port and successive approximation sequencer
// Assumes: all pins synchronous to core_clk; oscillator seen as a level
// Notes:   open-drain pins are output enables only; the pin level is low
//          whenever its enable is high
// Notes on behaviour
// [RL1] host holds select low and sends a 2-bit channel code serially
// [RL2] each serial clock rise shifts the input bit into the 9-bit register
// [RL3] falling latch strobe copies the upper 2 shift bits into the channel latch
// [RL4] latched code picks input 0 to 3, bit 0 is the low weight
// [RL5] select high ignores host pins, floats serial output, runs conversions
// [RL6] result formed by successive approximation against an 8-bit dac
// [RL7] one conversion takes exactly 56 internal oscillator periods
// [RL8] last step loads result into shift register and flags end of conversion
// [RL9] with select still high a new conversion starts at once, forever
// [RL10] channel input and serial output only while select is low
// [RL11] in a select-low window host reads result and may reload channel
// [RL12] serial output valid only 5 oscillator periods after select falls
// [RL13] serial output changes on serial clock falls, floats while select high
// [RL14] end of conversion driven only while select high
// [RL15] result leaves msb first, one bit per serial clock
// [RL16] end of conversion stays asserted until select next falls
`timescale 1ns/1ns
`include "ssa_consts.svh"

module ssa_sequencer
  import ssa_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // host side pins
  input  wire ssa_host_pins_t            host_pins,
  // internal oscillator
  input  wire logic                      osc_pin_a,
  // analog front end
  input  wire logic                      cmp_above,
  output logic [`SSA_CODE_W-1:0]         dac_code,
  output logic [`SSA_CHAN_W-1:0]         mux_sel,
  // open-drain pin controls
  output logic                           so_oe,
  output logic                           eoc_n_oe
);

  ssa_state_t                 state_q;
  ssa_state_t                 state_d;
  logic [`SSA_TICK_W-1:0]     tick_q;
  logic [`SSA_TICK_W-1:0]     tick_d;
  logic [`SSA_CODE_W-1:0]     approx_register_q;
  logic [`SSA_CODE_W-1:0]     approx_register_d;
  logic [`SSA_SHIFT_W-1:0]    shift_q;
  logic [`SSA_SHIFT_W-1:0]    shift_d;
  logic [`SSA_CHAN_W-1:0]     chan_q;
  logic [`SSA_CHAN_W-1:0]     chan_d;
  logic [`SSA_READY_W-1:0]    ready_cnt_q;
  logic [`SSA_READY_W-1:0]    ready_cnt_d;
  logic                       ready_q;
  logic                       ready_d;
  logic                       so_q;
  logic                       so_d;
  logic                       eoc_q;
  logic                       eoc_d;

  logic                       cs_fall;
  logic                       sck_rise;
  logic                       sck_fall;
  logic                       strobe_fall;
  logic                       osc_tick;
  logic                       iface;

  ssa_edge #(.RST_VAL(1'b1)) u_cs_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .sig      (host_pins.cs_n),
    .rise     (),
    .fall     (cs_fall)
  );

  ssa_edge #(.RST_VAL(1'b1)) u_sck_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .sig      (host_pins.sck),
    .rise     (sck_rise),
    .fall     (sck_fall)
  );

  ssa_edge #(.RST_VAL(1'b0)) u_strobe_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .sig      (host_pins.addr_latch_strobe),
    .rise     (),
    .fall     (strobe_fall)
  );

  ssa_edge #(.RST_VAL(1'b0)) u_osc_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .sig      (osc_pin_a),
    .rise     (osc_tick),
    .fall     ()
  );

  // host pins count only while select is low
  assign iface = ~host_pins.cs_n; // RL5 RL10

  // sequencer: state, tick counter, approximation register
  always_comb begin
    logic [`SSA_CODE_W-1:0] trial;
    trial             = approx_register_q;
    state_d           = state_q;
    tick_d            = tick_q;
    approx_register_d = approx_register_q;
    case (state_q)
      SSA_ST_IFACE: begin
        tick_d = '0;
        if (!iface) begin
          state_d           = SSA_ST_CONV; // RL5 RL11
          approx_register_d = `SSA_CODE_RST;
        end
      end
      SSA_ST_CONV: begin
        if (iface) begin
          // a select fall aborts a conversion; the shift register keeps its old bits
          state_d = SSA_ST_IFACE; // RL11
          tick_d  = '0;
        end else if (osc_tick) begin
          for (int k = 0; k < `SSA_CODE_W; k++) begin
            if (tick_q == `SSA_TICK_W'(`SSA_SAMPLE_TICKS + `SSA_STEP_TICKS * k)) begin
              trial[`SSA_CODE_W-1-k] = 1'b1; // RL6
            end
            if (tick_q == `SSA_TICK_W'(`SSA_SAMPLE_TICKS + `SSA_STEP_TICKS * k
                                      + `SSA_DECIDE_OFS)) begin
              if (!cmp_above) begin
                trial[`SSA_CODE_W-1-k] = 1'b0; // RL6
              end
            end
          end
          if (tick_q == `SSA_CONV_TICKS - 6'h01) begin
            tick_d            = '0; // RL7 RL9
            approx_register_d = `SSA_CODE_RST; // RL9
          end else begin
            tick_d            = tick_q + 6'h01; // RL7
            approx_register_d = trial;
          end
        end
      end
      default: begin
        state_d           = SSA_ST_IFACE;
        tick_d            = '0;
        approx_register_d = `SSA_CODE_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q           <= SSA_ST_IFACE;
      tick_q            <= '0;
      approx_register_q <= `SSA_CODE_RST;
    end else begin
      state_q           <= state_d;
      tick_q            <= tick_d;
      approx_register_q <= approx_register_d;
    end
  end

  // final result: last trial bit decided at the last tick
  logic                   conv_done;
  logic [`SSA_CODE_W-1:0] final_code;

  always_comb begin
    conv_done  = (state_q == SSA_ST_CONV) && !iface && osc_tick
                 && (tick_q == `SSA_CONV_TICKS - 6'h01); // RL7
    final_code = approx_register_q;
    if (!cmp_above) begin
      final_code[0] = 1'b0; // RL6
    end
  end

  // host port: shift register, channel latch, serial output
  always_comb begin
    shift_d     = shift_q;
    chan_d      = chan_q;
    ready_cnt_d = ready_cnt_q;
    ready_d     = ready_q;
    so_d        = so_q;
    eoc_d       = eoc_q;
    if (conv_done) begin
      // result lands msb at bit 0 so it leaves first, ahead of the zero in bit 8
      for (int i = 0; i < `SSA_CODE_W; i++) begin
        shift_d[i] = final_code[`SSA_CODE_W-1-i]; // RL8 RL15
      end
      shift_d[`SSA_SHIFT_W-1] = 1'b0;
      eoc_d = 1'b1; // RL8
    end
    if (cs_fall) begin
      eoc_d       = 1'b0; // RL16
      ready_cnt_d = '0;
      ready_d     = 1'b0;
    end else if (iface) begin
      if (osc_tick && !ready_q) begin
        if (ready_cnt_q == `SSA_READY_TICKS - 3'h1) begin
          ready_d = 1'b1; // RL12
          so_d    = shift_q[0];
        end else begin
          ready_cnt_d = ready_cnt_q + 3'h1; // RL12
        end
      end
      if (sck_rise) begin
        shift_d = {host_pins.si, shift_q[`SSA_SHIFT_W-1:1]}; // RL2 RL10
      end
      if (sck_fall && ready_q) begin
        so_d = shift_q[0]; // RL13 RL15
      end
      if (strobe_fall) begin
        chan_d = shift_q[`SSA_SHIFT_W-1 -: `SSA_CHAN_W]; // RL3
      end
    end else begin
      // drop ready while select is high, else the next window drives early
      ready_d = 1'b0; // RL12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_q     <= `SSA_SHIFT_RST;
      chan_q      <= `SSA_CHAN_RST;
      ready_cnt_q <= '0;
      ready_q     <= 1'b0;
      so_q        <= 1'b1;
      eoc_q       <= 1'b0;
    end else begin
      shift_q     <= shift_d;
      chan_q      <= chan_d;
      ready_cnt_q <= ready_cnt_d;
      ready_q     <= ready_d;
      so_q        <= so_d;
      eoc_q       <= eoc_d;
    end
  end

  assign dac_code = approx_register_q; // RL6
  assign mux_sel  = chan_q; // RL4
  // open drain: enable pulls the line low
  assign so_oe    = iface & ready_q & ~so_q; // RL13
  assign eoc_n_oe = ~iface & eoc_q; // RL14 RL16

endmodule : ssa_sequencer

/* sim/ssa_sequencer_properties.sv */
// Purpose: pin-level checks of the serial sar sequencer
// Assumes: the oscillator level is held low while rst is high
// Notes:   tick counters follow the sequencer's own tick numbering
`timescale 1ns/1ns
`include "ssa_consts.svh"

module ssa_sequencer_properties
  import ssa_pkg::*;
(
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // pins seen at the top
  input wire ssa_host_pins_t         host_pins,
  input wire logic                   osc_pin_a,
  input wire logic                   cmp_above,
  input wire logic [`SSA_CODE_W-1:0] dac_code,
  input wire logic [`SSA_CHAN_W-1:0] mux_sel,
  input wire logic                   so_oe,
  input wire logic                   eoc_n_oe
);
  logic       osc_q, cs_q, lat_q;
  logic [6:0] ct_q, ct_d;
  logic [2:0] rt_q, rt_d;
  wire  logic tick     = osc_pin_a & ~osc_q;
  wire  logic lat_fall = lat_q & ~host_pins.addr_latch_strobe & ~host_pins.cs_n;

  // ct: ticks since conversion entry, rt: ticks since select fell
  always_comb begin
    ct_d = ct_q;
    rt_d = rt_q;
    if (!host_pins.cs_n) ct_d = 7'h00;
    else if (tick && cs_q && ct_q != 7'h7F) ct_d = ct_q + 7'h01;
    if (host_pins.cs_n) rt_d = 3'h0;
    else if (tick && rt_q != 3'h7) rt_d = rt_q + 3'h1;
  end

  always_ff @(posedge core_clk) begin
    osc_q <= osc_pin_a;
    lat_q <= host_pins.addr_latch_strobe;
    cs_q  <= rst ? 1'b0 : host_pins.cs_n;
    ct_q  <= rst ? 7'h00 : ct_d;
    rt_q  <= rst ? 3'h0 : rt_d;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  so_float_a: assert property (host_pins.cs_n |-> !so_oe)
    else $error("serial out driven while select high");
  eoc_float_a: assert property (!host_pins.cs_n |-> !eoc_n_oe)
    else $error("end flag driven while select low");
  so_ready_a: assert property (so_oe |-> rt_q >= 3'h5)
    else $error("serial out before five ticks");
  so_stable_a: assert property (rt_q == 3'h7 && !host_pins.cs_n && host_pins.sck
    && $past(host_pins.sck)
    && $past(host_pins.sck, 2) |-> $stable(so_oe))
    else $error("serial out moved without a clock fall");
  mux_hold_a: assert property ($changed(mux_sel) |-> $past(lat_fall) || $past(lat_fall, 2))
    else $error("channel changed without a strobe fall");
  eoc_hold_a: assert property ($fell(eoc_n_oe) |-> !host_pins.cs_n)
    else $error("end flag dropped while select high");
  eoc_time_a: assert property ($rose(eoc_n_oe) |-> ct_q == 7'h38)
    else $error("conversion length wrong");
  dac_clear_a: assert property (ct_q inside {[7'h01:7'h08]} |-> dac_code == 8'h00)
    else $error("trial code not clear while settling");
  dac_msb_a: assert property (ct_q inside {[7'h09:7'h0D]} |-> dac_code == 8'h80)
    else $error("first trial code wrong");

  eoc_seen_c: cover property ($rose(eoc_n_oe));
  lat_seen_c: cover property (lat_fall);
  so_seen_c: cover property (so_oe);
endmodule : ssa_sequencer_properties

bind ssa_sequencer ssa_sequencer_properties u_props (.core_clk, .rst, .host_pins, .osc_pin_a,
  .cmp_above, .dac_code, .mux_sel, .so_oe, .eoc_n_oe);

/* sim/ssa_host_model.sv */
// Purpose: host controller driving select, serial clock, data and strobe
// Assumes: serial out level is the inverse of its pull-low enable
// Notes:   tasks are called from the bench; pins idle with select high
`timescale 1ns/1ns

module ssa_host_model
  import ssa_pkg::*;
(
  // timing
  input wire logic     core_clk,
  input wire logic     osc_pin_a,
  // pins
  output ssa_host_pins_t host_pins,
  input wire logic     so_oe
);
  initial host_pins = 4'hC;

  task automatic clk2();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : clk2

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge osc_pin_a);
    @(posedge core_clk);
    #1;
  endtask : wait_ticks

  // one select-low window: read 9 bits, load a channel, select high again
  task automatic xfer(input logic [1:0] chan, output logic [8:0] got);
    host_pins.cs_n = 1'b0;
    wait_ticks(6);
    host_pins.sck = 1'b0;
    clk2();
    for (int i = 0; i < 9; i++) begin
      got = {got[7:0], ~so_oe};
      host_pins.si = (i > 6) ? chan[i - 7] : 1'b0;
      host_pins.sck = 1'b1;
      clk2();
      // the ninth rise is the last; sck stays high so no tenth shift happens
      if (i < 8) begin
        host_pins.sck = 1'b0;
        clk2();
      end
    end
    host_pins.addr_latch_strobe = 1'b1;
    clk2();
    host_pins.addr_latch_strobe = 1'b0;
    clk2();
    host_pins.cs_n = 1'b1;
  endtask : xfer

  // pin activity that must be ignored while select is high
  task automatic noise();
    repeat (4) begin
      host_pins[2:0] = ~host_pins[2:0];
      clk2();
    end
  endtask : noise
endmodule : ssa_host_model

/* sim/ssa_sequencer_tb.sv */
// Purpose: self-checking bench of the serial sar sequencer
// Assumes: comparator modelled as one fixed level per channel
// Notes:   osc runs at a quarter of core_clk and stands low in reset
`timescale 1ns/1ns

module ssa_sequencer_tb;
  import ssa_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  logic           osc_pin_a = 1'b0;
  logic [1:0]     ph = 2'h0;
  ssa_host_pins_t host_pins;
  logic [7:0]     dac_code, prev;
  logic [1:0]     mux_sel;
  logic           so_oe, eoc_n_oe;
  logic [8:0]     got;
  logic [7:0]     ain [4] = '{8'h3C, 8'hFF, 8'h00, 8'hA5};
  logic [9:0]     rows [4] = '{{2'h1, 8'hFF}, {2'h3, 8'hA5}, {2'h2, 8'h00}, {2'h0, 8'h3C}};
  int             failures = 0;
  int             check_count = 0;
  int             cyc = 0;
  wire logic      cmp_above = ain[mux_sel] >= dac_code;

  ssa_sequencer uut (.core_clk, .rst, .host_pins, .osc_pin_a, .cmp_above, .dac_code,
    .mux_sel, .so_oe, .eoc_n_oe);
  ssa_host_model hm (.core_clk, .osc_pin_a, .host_pins, .so_oe);

  always #2 core_clk = ~core_clk;

  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    ph <= ph + 2'h1;
    osc_pin_a <= !rst && ph[1];
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    check("reset dac mux", 10'h000, {dac_code, mux_sel});
    check("reset oe", 10'h000, {8'h00, so_oe, eoc_n_oe});
    rst = 1'b0;
  endtask : do_reset

  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_n_oe !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("eoc", 10'h001, {9'h000, eoc_n_oe});
  endtask : wait_eoc

  initial begin
    do_reset();
    prev = 8'h3C;
    for (int i = 0; i < 5; i++) begin
      wait_eoc();
      hm.xfer(rows[i % 4][9:8], got);
      check("result", {1'b0, prev, 1'b0}, {1'b0, got});
      check("mux_sel", {8'h00, rows[i % 4][9:8]}, {8'h00, mux_sel});
      prev = rows[i % 4][7:0];
    end
    // select low mid-conversion: no new result, old shift bits come out
    hm.wait_ticks(20);
    hm.xfer(2'h2, got);
    check("abort", 10'h002, {1'b0, got});
    wait_eoc();
    hm.noise();
    repeat (300) @(posedge core_clk);
    #1;
    check("eoc held", 10'h001, {9'h000, eoc_n_oe});
    check("mux kept", 10'h002, {8'h00, mux_sel});
    hm.xfer(2'h0, got);
    check("repeat result", {1'b0, 8'h00, 1'b0}, {1'b0, got});
    do_reset();
    wait_eoc();
    hm.xfer(2'h0, got);
    check("after reset", {1'b0, ain[0], 1'b0}, {1'b0, got});
    print_verdict();
  end
endmodule : ssa_sequencer_tb
